// file: hw/scb_cfg.svh
// register offsets, field positions, reset values and timing counts of the config bank
`ifndef SCB_CFG_SVH
`define SCB_CFG_SVH

`define SCB_OFS_RATE_WIDTH 4'h0
`define SCB_OFS_SPREAD 4'h1
`define SCB_OFS_TIMER1 4'h2
`define SCB_OFS_TIMER2 4'h3
`define SCB_OFS_EDGE_CTL 4'h4
`define SCB_OFS_OWN_ADDR 4'h5
`define SCB_OFS_END_FRAME 4'h6
`define SCB_OFS_PEER_ADDR 4'h7
`define SCB_OFS_PERIPH 4'h8
`define SCB_OFS_TEST_UPPER 4'h9
`define SCB_OFS_LOW_DIR 4'hA
`define SCB_OFS_LOW_VAL 4'hB
`define SCB_OFS_BOOST 4'hC
`define SCB_OFS_DEGLITCH 4'hD
`define SCB_OFS_LOCK 4'hE

`define SCB_RST_RATE_WIDTH 8'hB5
`define SCB_RST_SPREAD 8'h1F
`define SCB_RST_TIMER 8'hA0
`define SCB_RST_EDGE_STRAP_LO 8'h28
`define SCB_RST_EDGE_STRAP_HI 8'h30
`define SCB_RST_OWN_ADDR 8'hFA
`define SCB_RST_END_FRAME 8'hFF
`define SCB_RST_PEER_ADDR 8'hF8
`define SCB_RST_PERIPH 8'h00
`define SCB_RST_TEST_UPPER 8'h00
`define SCB_RST_LOW_DIR 8'h00
`define SCB_RST_LOW_VAL 8'h00
`define SCB_RST_BOOST 8'hE0
`define SCB_RST_DEGLITCH 8'h00

// writable masks; bits outside them are reserved and hold their reset value
`define SCB_WMASK_SPREAD 8'hE0
`define SCB_WMASK_EDGE_CTL 8'hBD
`define SCB_WMASK_BOOST 8'hE0
`define SCB_WMASK_DEGLITCH 8'h03

// edge/control register bit positions
`define SCB_BIT_VSYNC_EDGE 7
`define SCB_BIT_PCLK_POL 5
`define SCB_BIT_POWERDOWN 4
`define SCB_BIT_SER_EN 3
`define SCB_BIT_PLL_BYP 2
`define SCB_BIT_PRBS_EN 0

// deglitch widths in ns and clock period in ns
`define SCB_CLK_PERIOD_NS 5
`define SCB_FILT_SLOW_NS 100
`define SCB_FILT_MID_NS 50
`define SCB_FILT_FAST_NS 10
`define SCB_NS_TO_CYC(ns) (((ns) + `SCB_CLK_PERIOD_NS - 1) / `SCB_CLK_PERIOD_NS)

`endif

// file: hw/scb_pkg.sv
// types shared by the serializer configuration bank
package scb_pkg;
  typedef logic [3:0] scb_addr_t;
  typedef logic [7:0] scb_byte_t;
  typedef enum logic [1:0] {
    STRAP_SYNC1,
    STRAP_SYNC2,
    STRAP_LOAD,
    STRAP_DONE
  } scb_strap_e;
endpackage : scb_pkg

// file: hw/scb_regs.sv
// serializer configuration and status register bank, written over the control channel
// Operation
// R1: pixel-rate field resets to 10, meaning 20 to 40 MHz pixel clock.
// R2: serial-rate field resets to 11, meaning 400 to 840 Mbps.
// R3: parity enable resets 0; parallel width field resets 101, 18-bit word.
// R4: spread field resets 000 (off); its five reserved bits reset to ones.
// R5: first timer divider resets 1010 (div 1024), count field 0000 (count 1).
// R6: second timer divider resets 1010 (div 1024), count field 0000 (count 1).
// R7: vsync edge bit resets 0 (falling); pixel clock edge bit resets 1 (rising).
// R8: edge/control resets 0x28 with strap low, 0x30 with strap high.
// R9: jitter PLL bypass and PRBS enable both reset to 0.
// R10: own control-channel address resets to 0xFA.
// R11: end-of-frame code resets to 0xFF.
// R12: peer deserializer address resets to 0xF8.
// R13: peripheral interface type resets to UART and interface disabled.
// R14: UART speed bit resets 0, DC up to 4.25 Mbps.
// R15: comeback timeout field resets 000, never comes back.
// R16: base-mode bit-rate field resets 00, 95 to 400 kbps.
// R17: PRBS length field resets 0000, word length 2 to the 21.
// R18: ten pin direction bits (0 = input) and values reset to 0.
// R19: pre-emphasis field resets 111 (0%); five reserved bits reset to 0.
// R20: deglitch field resets 00; widths 100, 50, 10 ns per rate range.
// R21: last register shows link lock read-only; other bits read zero.
// R22: writes to reserved bits ignored; they keep their defaults.
// R23: selected vsync edge starts the control channel phase.
`timescale 1ns/1ps
`include "scb_cfg.svh"

module scb_regs (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire scb_pkg::scb_addr_t i_wr_addr,
  input wire scb_pkg::scb_byte_t i_wr_data,
  input wire logic i_rd_en,
  input wire scb_pkg::scb_addr_t i_rd_addr,
  input wire logic i_link_role_strap,
  input wire logic i_link_locked,
  input wire logic i_vsync,
  output logic o_rd_valid,
  output scb_pkg::scb_byte_t o_rd_data,
  output logic [1:0] o_pixel_rate_range,
  output logic [1:0] o_serial_rate_range,
  output logic o_parity_enable,
  output logic [2:0] o_parallel_width_sel,
  output logic [2:0] o_spread_sel,
  output logic [3:0] o_first_timer_divider,
  output logic [3:0] o_first_timer_count,
  output logic [3:0] o_second_timer_divider,
  output logic [3:0] o_second_timer_count,
  output logic o_vsync_edge_sel,
  output logic o_pixel_clock_polarity,
  output logic o_powerdown_ctl,
  output logic o_serial_out_enable,
  output logic o_jitter_pll_bypass,
  output logic o_prbs_test_enable,
  output scb_pkg::scb_byte_t o_own_link_addr,
  output scb_pkg::scb_byte_t o_end_frame_code,
  output scb_pkg::scb_byte_t o_peer_link_addr,
  output logic o_periph_iface_type,
  output logic o_periph_iface_on,
  output logic o_uart_fast,
  output logic [2:0] o_comeback_timeout_sel,
  output logic [1:0] o_base_bit_rate,
  output logic [3:0] o_prbs_length_sel,
  output logic [9:0] o_pin_direction,
  output logic [9:0] o_pin_value,
  output logic [2:0] o_tx_boost_level,
  output logic [1:0] o_bus_deglitch_sel,
  output logic [4:0] o_deglitch_cycles,
  output logic o_cc_phase_start
);
  import scb_pkg::*;

  localparam logic [4:0] FILT_SLOW_CYC = 5'(`SCB_NS_TO_CYC(`SCB_FILT_SLOW_NS));
  localparam logic [4:0] FILT_MID_CYC = 5'(`SCB_NS_TO_CYC(`SCB_FILT_MID_NS));
  localparam logic [4:0] FILT_FAST_CYC = 5'(`SCB_NS_TO_CYC(`SCB_FILT_FAST_NS));

  scb_byte_t rate_width_config;
  scb_byte_t spread_config;
  scb_byte_t first_timer_config;
  scb_byte_t second_timer_config;
  scb_byte_t edge_power_test_control;
  scb_byte_t own_link_address;
  scb_byte_t end_frame_code;
  scb_byte_t peer_link_address;
  scb_byte_t peripheral_iface_config;
  scb_byte_t test_length_upper_pins;
  scb_byte_t lower_pin_direction;
  scb_byte_t lower_pin_value;
  scb_byte_t tx_boost_config;
  scb_byte_t deglitch_config;
  scb_byte_t lock_status;
  scb_byte_t next_rd_data;
  scb_strap_e strap_state;
  logic strap_meta;
  logic strap_sync;
  logic lock_meta;
  logic lock_sync;
  logic vsync_meta;
  logic vsync_sync;
  logic vsync_prev;
  logic vsync_hit;

  // external levels cross into this clock through two flops
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
      vsync_meta <= 1'b0;
      vsync_sync <= 1'b0;
      vsync_prev <= 1'b0;
    end else begin
      strap_meta <= i_link_role_strap;
      strap_sync <= strap_meta;
      lock_meta <= i_link_locked;
      lock_sync <= lock_meta;
      vsync_meta <= i_vsync;
      vsync_sync <= vsync_meta;
      vsync_prev <= vsync_sync;
    end
  end

  // strap is caught after reset release once the synchroniser has filled
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_state <= STRAP_SYNC1;
    end else begin
      case (strap_state)
        STRAP_SYNC1: strap_state <= STRAP_SYNC2;
        STRAP_SYNC2: strap_state <= STRAP_LOAD;
        STRAP_LOAD: strap_state <= STRAP_DONE;
        default: strap_state <= STRAP_DONE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rate_width_config <= `SCB_RST_RATE_WIDTH; // R1 R2 R3
      first_timer_config <= `SCB_RST_TIMER; // R5
      second_timer_config <= `SCB_RST_TIMER; // R6
      own_link_address <= `SCB_RST_OWN_ADDR; // R10
      end_frame_code <= `SCB_RST_END_FRAME; // R11
      peer_link_address <= `SCB_RST_PEER_ADDR; // R12
      peripheral_iface_config <= `SCB_RST_PERIPH; // R13 R14 R15 R16
      test_length_upper_pins <= `SCB_RST_TEST_UPPER; // R17 R18
      lower_pin_direction <= `SCB_RST_LOW_DIR; // R18
      lower_pin_value <= `SCB_RST_LOW_VAL; // R18
    end else if (i_wr_en) begin
      if (i_wr_addr == `SCB_OFS_RATE_WIDTH) begin
        rate_width_config <= i_wr_data;
      end else if (i_wr_addr == `SCB_OFS_TIMER1) begin
        first_timer_config <= i_wr_data;
      end else if (i_wr_addr == `SCB_OFS_TIMER2) begin
        second_timer_config <= i_wr_data;
      end else if (i_wr_addr == `SCB_OFS_OWN_ADDR) begin
        own_link_address <= i_wr_data;
      end else if (i_wr_addr == `SCB_OFS_END_FRAME) begin
        end_frame_code <= i_wr_data;
      end else if (i_wr_addr == `SCB_OFS_PEER_ADDR) begin
        peer_link_address <= i_wr_data;
      end else if (i_wr_addr == `SCB_OFS_PERIPH) begin
        peripheral_iface_config <= i_wr_data;
      end else if (i_wr_addr == `SCB_OFS_TEST_UPPER) begin
        test_length_upper_pins <= i_wr_data;
      end else if (i_wr_addr == `SCB_OFS_LOW_DIR) begin
        lower_pin_direction <= i_wr_data;
      end else if (i_wr_addr == `SCB_OFS_LOW_VAL) begin
        lower_pin_value <= i_wr_data;
      end
    end
  end

  // registers with reserved bits: only the writable mask is taken
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      spread_config <= `SCB_RST_SPREAD; // R4
      tx_boost_config <= `SCB_RST_BOOST; // R19
      deglitch_config <= `SCB_RST_DEGLITCH; // R20
    end else if (i_wr_en) begin
      if (i_wr_addr == `SCB_OFS_SPREAD) begin
        spread_config <= (i_wr_data & `SCB_WMASK_SPREAD)
          | (`SCB_RST_SPREAD & ~`SCB_WMASK_SPREAD); // R22
      end else if (i_wr_addr == `SCB_OFS_BOOST) begin
        tx_boost_config <= (i_wr_data & `SCB_WMASK_BOOST)
          | (`SCB_RST_BOOST & ~`SCB_WMASK_BOOST); // R22
      end else if (i_wr_addr == `SCB_OFS_DEGLITCH) begin
        deglitch_config <= (i_wr_data & `SCB_WMASK_DEGLITCH)
          | (`SCB_RST_DEGLITCH & ~`SCB_WMASK_DEGLITCH); // R22
      end
    end
  end

  // edge/control: strap-low value until the strap is caught; a host write
  // in the load cycle loses to the strap so the default is never skipped
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      edge_power_test_control <= `SCB_RST_EDGE_STRAP_LO; // R7 R9
    end else if (strap_state == STRAP_LOAD) begin
      edge_power_test_control <= strap_sync ? `SCB_RST_EDGE_STRAP_HI
                                            : `SCB_RST_EDGE_STRAP_LO; // R8
    end else if (i_wr_en && (i_wr_addr == `SCB_OFS_EDGE_CTL)) begin
      edge_power_test_control <= (i_wr_data & `SCB_WMASK_EDGE_CTL)
        | (`SCB_RST_EDGE_STRAP_LO & ~`SCB_WMASK_EDGE_CTL); // R22
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      lock_status <= 8'h00;
    end else begin
      lock_status <= {7'h00, lock_sync}; // R21
    end
  end

  always_comb begin
    next_rd_data = 8'h00;
    if (i_rd_addr == `SCB_OFS_RATE_WIDTH) begin
      next_rd_data = rate_width_config;
    end else if (i_rd_addr == `SCB_OFS_SPREAD) begin
      next_rd_data = spread_config;
    end else if (i_rd_addr == `SCB_OFS_TIMER1) begin
      next_rd_data = first_timer_config;
    end else if (i_rd_addr == `SCB_OFS_TIMER2) begin
      next_rd_data = second_timer_config;
    end else if (i_rd_addr == `SCB_OFS_EDGE_CTL) begin
      next_rd_data = edge_power_test_control;
    end else if (i_rd_addr == `SCB_OFS_OWN_ADDR) begin
      next_rd_data = own_link_address;
    end else if (i_rd_addr == `SCB_OFS_END_FRAME) begin
      next_rd_data = end_frame_code;
    end else if (i_rd_addr == `SCB_OFS_PEER_ADDR) begin
      next_rd_data = peer_link_address;
    end else if (i_rd_addr == `SCB_OFS_PERIPH) begin
      next_rd_data = peripheral_iface_config;
    end else if (i_rd_addr == `SCB_OFS_TEST_UPPER) begin
      next_rd_data = test_length_upper_pins;
    end else if (i_rd_addr == `SCB_OFS_LOW_DIR) begin
      next_rd_data = lower_pin_direction;
    end else if (i_rd_addr == `SCB_OFS_LOW_VAL) begin
      next_rd_data = lower_pin_value;
    end else if (i_rd_addr == `SCB_OFS_BOOST) begin
      next_rd_data = tx_boost_config;
    end else if (i_rd_addr == `SCB_OFS_DEGLITCH) begin
      next_rd_data = deglitch_config;
    end else if (i_rd_addr == `SCB_OFS_LOCK) begin
      next_rd_data = lock_status; // R21
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= 8'h00;
    end else begin
      o_rd_valid <= i_rd_en;
      o_rd_data <= i_rd_en ? next_rd_data : 8'h00;
    end
  end

  // falling edge when the select bit is 0, rising when 1
  assign vsync_hit = edge_power_test_control[`SCB_BIT_VSYNC_EDGE]
                     ? (vsync_sync & ~vsync_prev)
                     : (~vsync_sync & vsync_prev);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cc_phase_start <= 1'b0;
    end else begin
      o_cc_phase_start <= vsync_hit; // R23
    end
  end

  // width sized for the slowest range; code 11 reuses the fastest width
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_deglitch_cycles <= FILT_SLOW_CYC;
    end else begin
      case (deglitch_config[1:0])
        2'h0: o_deglitch_cycles <= FILT_SLOW_CYC; // R20
        2'h1: o_deglitch_cycles <= FILT_MID_CYC; // R20
        default: o_deglitch_cycles <= FILT_FAST_CYC; // R20
      endcase
    end
  end

  // field outputs: each is a slice of a register flop, except pin direction and value, which join slices of two registers
  assign o_pixel_rate_range = rate_width_config[7:6];
  assign o_serial_rate_range = rate_width_config[5:4];
  assign o_parity_enable = rate_width_config[3];
  assign o_parallel_width_sel = rate_width_config[2:0];
  assign o_spread_sel = spread_config[7:5];
  assign o_first_timer_divider = first_timer_config[7:4];
  assign o_first_timer_count = first_timer_config[3:0];
  assign o_second_timer_divider = second_timer_config[7:4];
  assign o_second_timer_count = second_timer_config[3:0];
  assign o_vsync_edge_sel = edge_power_test_control[`SCB_BIT_VSYNC_EDGE];
  assign o_pixel_clock_polarity = edge_power_test_control[`SCB_BIT_PCLK_POL];
  assign o_powerdown_ctl = edge_power_test_control[`SCB_BIT_POWERDOWN];
  assign o_serial_out_enable = edge_power_test_control[`SCB_BIT_SER_EN];
  assign o_jitter_pll_bypass = edge_power_test_control[`SCB_BIT_PLL_BYP];
  assign o_prbs_test_enable = edge_power_test_control[`SCB_BIT_PRBS_EN];
  assign o_own_link_addr = own_link_address;
  assign o_end_frame_code = end_frame_code;
  assign o_peer_link_addr = peer_link_address;
  assign o_periph_iface_type = peripheral_iface_config[7];
  assign o_periph_iface_on = peripheral_iface_config[6];
  assign o_uart_fast = peripheral_iface_config[5];
  assign o_comeback_timeout_sel = peripheral_iface_config[4:2];
  assign o_base_bit_rate = peripheral_iface_config[1:0];
  assign o_prbs_length_sel = test_length_upper_pins[7:4];
  assign o_pin_direction = {test_length_upper_pins[3:2], lower_pin_direction};
  assign o_pin_value = {test_length_upper_pins[1:0], lower_pin_value};
  assign o_tx_boost_level = tx_boost_config[7:5];
  assign o_bus_deglitch_sel = deglitch_config[1:0];
endmodule : scb_regs

// file: testbench/scb_regs_assertions.sv
// concurrent checks on the configuration bank ports
`timescale 1ns/1ps
module scb_regs_assertions (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire scb_pkg::scb_addr_t i_wr_addr,
  input wire scb_pkg::scb_byte_t i_wr_data,
  input wire logic i_rd_en,
  input wire scb_pkg::scb_addr_t i_rd_addr,
  input wire logic i_vsync,
  input wire logic o_rd_valid,
  input wire scb_pkg::scb_byte_t o_rd_data,
  input wire logic [1:0] o_pixel_rate_range,
  input wire logic [1:0] o_serial_rate_range,
  input wire logic o_parity_enable,
  input wire logic [2:0] o_parallel_width_sel,
  input wire logic [2:0] o_spread_sel,
  input wire scb_pkg::scb_byte_t o_own_link_addr,
  input wire logic o_vsync_edge_sel,
  input wire logic [1:0] o_bus_deglitch_sel,
  input wire logic [4:0] o_deglitch_cycles,
  input wire logic o_cc_phase_start
);
  import scb_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_read_req(scb_addr_t a);
    i_rd_en && i_rd_addr == a;
  endsequence
  // pin edge as seen at the sampling clock, before the sync stages
  sequence s_sel_edge;
    ($fell(i_vsync) && !o_vsync_edge_sel) || ($rose(i_vsync) && o_vsync_edge_sel);
  endsequence
  a_rd_answer: assert property (i_rd_en |=> o_rd_valid) else $error("read not answered");
  a_rd_quiet: assert property (!i_rd_en |=> !o_rd_valid && o_rd_data == 8'h00)
    else $error("read outputs active without a read");
  a_rate_write: assert property (i_wr_en && i_wr_addr == 4'h0 |=>
    {o_pixel_rate_range, o_serial_rate_range, o_parity_enable, o_parallel_width_sel}
    == $past(i_wr_data)) else $error("rate/width fields not written");
  a_spread_write: assert property (i_wr_en && i_wr_addr == 4'h1 |=>
    o_spread_sel == $past(i_wr_data[7:5])) else $error("spread field not written");
  a_spread_rsvd: assert property (s_read_req(4'h1) |=> o_rd_data[4:0] == 5'h1F)
    else $error("spread reserved bits changed");
  a_own_addr: assert property (i_wr_en && i_wr_addr == 4'h5 |=>
    o_own_link_addr == $past(i_wr_data)) else $error("own address not written");
  a_edge_rsvd: assert property (s_read_req(4'h4) |=> !o_rd_data[6] && !o_rd_data[1])
    else $error("edge register reserved bits set");
  a_lock_rsvd: assert property (s_read_req(4'hE) |=> o_rd_data[7:1] == 7'h00)
    else $error("lock register upper bits set");
  a_unmapped_zero: assert property (s_read_req(4'hF) |=> o_rd_data == 8'h00)
    else $error("unmapped offset read nonzero");
  a_phase_start: assert property (s_sel_edge |-> ##[2:4] o_cc_phase_start)
    else $error("selected vsync edge gave no phase start");
  a_phase_pulse: assert property (o_cc_phase_start |=> !o_cc_phase_start)
    else $error("phase start longer than one cycle");
  a_filter_width: assert property ($stable(o_bus_deglitch_sel) |-> o_deglitch_cycles ==
    (o_bus_deglitch_sel == 2'h0 ? 5'h14 : o_bus_deglitch_sel == 2'h1 ? 5'h0A : 5'h02))
    else $error("deglitch width wrong");
  c_sel_edge: cover property (s_sel_edge);
endmodule : scb_regs_assertions

bind scb_regs scb_regs_assertions u_chk (.i_sys_clk, .i_rst, .i_wr_en, .i_wr_addr,
  .i_wr_data, .i_rd_en, .i_rd_addr, .i_vsync, .o_rd_valid, .o_rd_data, .o_pixel_rate_range,
  .o_serial_rate_range, .o_parity_enable, .o_parallel_width_sel, .o_spread_sel,
  .o_own_link_addr, .o_vsync_edge_sel, .o_bus_deglitch_sel, .o_deglitch_cycles,
  .o_cc_phase_start);

// file: testbench/scb_host_model.sv
// remote host model issuing control-channel register writes and reads
`timescale 1ns/1ps
module scb_host_model (
  input wire logic i_sys_clk,
  input wire logic i_rd_valid,
  input wire scb_pkg::scb_byte_t i_rd_data,
  output logic o_wr_en,
  output scb_pkg::scb_addr_t o_wr_addr,
  output scb_pkg::scb_byte_t o_wr_data,
  output logic o_rd_en,
  output scb_pkg::scb_addr_t o_rd_addr
);
  import scb_pkg::*;
  initial begin
    o_wr_en = 1'h0;
    o_wr_addr = 4'h0;
    o_wr_data = 8'h00;
    o_rd_en = 1'h0;
    o_rd_addr = 4'h0;
  end
  // idle address and data are inverted so stale values never look valid
  task automatic wr(input scb_addr_t a, input scb_byte_t d);
    @(negedge i_sys_clk);
    o_wr_en = 1'h1;
    o_wr_addr = a;
    o_wr_data = d;
    @(negedge i_sys_clk);
    o_wr_en = 1'h0;
    o_wr_addr = ~a;
    o_wr_data = ~d;
  endtask : wr
  task automatic rd(input scb_addr_t a, output scb_byte_t d);
    @(negedge i_sys_clk);
    o_rd_en = 1'h1;
    o_rd_addr = a;
    @(negedge i_sys_clk);
    o_rd_en = 1'h0;
    o_rd_addr = ~a;
    d = (i_rd_valid === 1'h1) ? i_rd_data : 8'hXX;
  endtask : rd
endmodule : scb_host_model

// file: testbench/scb_regs_tb.sv
// self-checking bench for the serializer configuration bank
`timescale 1ns/1ps
module scb_regs_tb;
  import scb_pkg::*;
  logic i_sys_clk = 1'h0;
  logic i_rst = 1'h1;
  logic i_link_role_strap = 1'h0;
  logic i_link_locked = 1'h0;
  logic i_vsync = 1'h0;
  logic wr_en, rd_en, rd_valid, cc_start, pd, ser_en;
  scb_addr_t wr_addr, rd_addr;
  scb_byte_t wr_data, rd_data, v;
  logic [9:0] pin_dir, pin_val;
  logic [4:0] dg_cyc;
  logic [1:0] prr, srr, bbr, dgs;
  logic par, vse, pcp, pll, prbs, pit, pio, uf;
  logic [2:0] pws, sps, comeback_timeout_sel, txb;
  logic [3:0] t1d, t1c, t2d, t2c, pls;
  scb_byte_t own, eof, peer;
  logic [31:0] seed = 32'h5D0402B9;
  logic [31:0] r;
  scb_byte_t mdl [16];
  int errors = 0;
  int check_count = 0;
  int pulses = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (cc_start === 1'h1) pulses++;
  scb_regs u_dut (.i_sys_clk, .i_rst, .i_wr_en(wr_en), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .i_rd_en(rd_en), .i_rd_addr(rd_addr), .i_link_role_strap,
    .i_link_locked, .i_vsync, .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .o_pixel_rate_range(prr), .o_serial_rate_range(srr), .o_parity_enable(par),
    .o_parallel_width_sel(pws), .o_spread_sel(sps), .o_first_timer_divider(t1d),
    .o_first_timer_count(t1c), .o_second_timer_divider(t2d), .o_second_timer_count(t2c),
    .o_vsync_edge_sel(vse), .o_pixel_clock_polarity(pcp), .o_powerdown_ctl(pd),
    .o_serial_out_enable(ser_en), .o_jitter_pll_bypass(pll), .o_prbs_test_enable(prbs),
    .o_own_link_addr(own), .o_end_frame_code(eof), .o_peer_link_addr(peer),
    .o_periph_iface_type(pit), .o_periph_iface_on(pio), .o_uart_fast(uf),
    .o_comeback_timeout_sel(comeback_timeout_sel), .o_base_bit_rate(bbr),
    .o_prbs_length_sel(pls), .o_pin_direction(pin_dir), .o_pin_value(pin_val),
    .o_tx_boost_level(txb), .o_bus_deglitch_sel(dgs), .o_deglitch_cycles(dg_cyc),
    .o_cc_phase_start(cc_start));
  scb_host_model u_host (.i_sys_clk, .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_en(rd_en),
    .o_rd_addr(rd_addr));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic scb_byte_t rstv(scb_addr_t a, logic s);
    case (a)
      4'h0: return 8'hB5;
      4'h1: return 8'h1F;
      4'h2, 4'h3: return 8'hA0;
      4'h4: return s ? 8'h30 : 8'h28;
      4'h5: return 8'hFA;
      4'h6: return 8'hFF;
      4'h7: return 8'hF8;
      4'hC: return 8'hE0;
      default: return 8'h00;
    endcase
  endfunction : rstv
  function automatic scb_byte_t wmask(scb_addr_t a);
    case (a)
      4'h1, 4'hC: return 8'hE0;
      4'h4: return 8'hBD;
      4'hD: return 8'h03;
      4'hE, 4'hF: return 8'h00;
      default: return 8'hFF;
    endcase
  endfunction : wmask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // six idle cycles let the strap load land before any access
  task automatic do_reset(input logic s);
    @(negedge i_sys_clk);
    i_rst = 1'h1;
    i_link_role_strap = s;
    repeat (2) @(negedge i_sys_clk);
    i_rst = 1'h0;
    repeat (6) @(negedge i_sys_clk);
    for (int a = 0; a < 16; a++) mdl[a] = rstv(a[3:0], s);
    mdl[14] = {7'h00, i_link_locked};
  endtask : do_reset
  task automatic check_all();
    for (int a = 0; a < 16; a++) begin
      u_host.rd(a[3:0], v);
      chk(16'(v), 16'(mdl[a]));
    end
    chk(16'(pin_dir), 16'({mdl[9][3:2], mdl[10]}));
    chk(16'(pin_val), 16'({mdl[9][1:0], mdl[11]}));
    // field ports must mirror the register contents bit for bit
    chk(16'({prr, srr, par, pws}), 16'(mdl[0]));
    chk(16'(sps), 16'(mdl[1][7:5]));
    chk({t1d, t1c, t2d, t2c}, {mdl[2], mdl[3]});
    chk(16'({vse, 1'h0, pcp, pd, ser_en, pll, 1'h0, prbs}), 16'(mdl[4]));
    chk({own, eof}, {mdl[5], mdl[6]});
    chk(16'(peer), 16'(mdl[7]));
    chk(16'({pit, pio, uf, comeback_timeout_sel, bbr}), 16'(mdl[8]));
    chk(16'({pls, txb, dgs}), 16'({mdl[9][7:4], mdl[12][7:5], mdl[13][1:0]}));
  endtask : check_all
  initial begin
    #100000;
    errors++;
    test_done();
  end
  initial begin
    do_reset(1'h0);
    check_all();
    chk(16'({pd, ser_en}), 16'h0001);
    for (int n = 0; n < 300; n++) begin
      r = xs();
      u_host.wr(r[11:8], r[7:0]);
      mdl[r[11:8]] = (mdl[r[11:8]] & ~wmask(r[11:8])) | (r[7:0] & wmask(r[11:8]));
      if (r[16]) begin
        i_link_locked = r[17];
        repeat (4) @(negedge i_sys_clk);
        mdl[14] = {7'h00, r[17]};
      end
      if (n % 60 == 0) check_all();
    end
    check_all();
    for (int c = 0; c < 4; c++) begin
      u_host.wr(4'hD, c[7:0]);
      @(negedge i_sys_clk);
      chk(16'(dg_cyc), c == 0 ? 16'h0014 : c == 1 ? 16'h000A : 16'h0002);
    end
    mdl[13] = 8'h03;
    for (int s = 0; s < 2; s++) begin
      u_host.wr(4'h4, {s[0], mdl[4][6:0]});
      mdl[4][7] = s[0];
      for (int e = 0; e < 2; e++) begin
        pulses = 0;
        i_vsync = ~i_vsync;
        repeat (8) @(negedge i_sys_clk);
        chk(16'(pulses), 16'(i_vsync == s[0]));
      end
    end
    check_all();
    do_reset(1'h1);
    check_all();
    chk(16'({pd, ser_en}), 16'h0002);
    test_done();
  end
endmodule : scb_regs_tb
